// [core/ctpl_pkg.sv]
/*
 * Constants for the lower-priority trap logic: register map, trap
 * store and transfer locations, flag positions, reset values, timing.
 * Assumes a 25 MHz APB clock and 36-bit words with bit 0 at index 35.
 */
//
// What this block does
// - protect mode on: protect trap at 00032/00033
// - protect trap fires when causing trap would
// - store octal 33 to cause, cause follows
// - protect trap clears protect mode, holds cause
// - timer carry requests overflow trap 00006/00007
// - overflow trap after cycle or instruction end
// - privileged instruction defers overflow and direct-data
// - overflow, direct-data, channel traps need trap control on, protect off
// - pending overflow blocks further timer updates
// - two blocked updates raise blast, clear overflow
// - direct-data interrupt traps at 00003/00004
// - masked channels B-E flag bits 16-13
// - taking trap clears channel trap control
// - restore re-enables control, honours waiting interrupts
// - new mask enable honours earlier waiting interrupts
// - completion on op-masked channel requests trap
// - request on going idle; E first, 22/20/16
// - timer word stepped 60 times per second
package ctpl_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CMD = 8'h04;
    localparam logic [7:0] OFF_MASK = 8'h08;
    localparam logic [7:0] OFF_PEND = 8'h0c;
    localparam logic [7:0] OFF_TIMER = 8'h10;
    localparam logic [7:0] OFF_LAST = 8'h14;
    localparam int CTRL_TRAP = 0;
    localparam int CTRL_PROT = 1;
    localparam int CTRL_CHTC = 2;
    localparam int CTRL_TEN = 3;
    localparam int CMD_SPM = 0;
    localparam int CMD_RCT = 1;
    localparam int CMD_ENB = 2;
    localparam int CMD_ICT = 3;
    localparam int CMD_RST = 4;
    localparam int CMD_DDM_LSB = 8;
    localparam int CMD_OPM_LSB = 12;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic RST_TRAP_CTL = 1'b1;
    localparam logic RST_PROTECT = 1'b0;
    localparam logic RST_CHAN_TC = 1'b0;
    localparam logic RST_TIMER_EN = 1'b0;
    // ------------------------------------------------------------
    // trap locations (octal addresses as 15-bit words)
    // ------------------------------------------------------------
    localparam logic [14:0] LOC_PI_STORE = 15'h001a;
    localparam logic [14:0] LOC_PI_XFER = 15'h001b;
    localparam logic [14:0] PI_CAUSE_DATA = 15'h001b;
    localparam logic [14:0] LOC_OVF_STORE = 15'h0006;
    localparam logic [14:0] LOC_OVF_XFER = 15'h0007;
    localparam logic [14:0] LOC_DD_STORE = 15'h0003;
    localparam logic [14:0] LOC_DD_XFER = 15'h0004;
    localparam logic [14:0] LOC_BLAST_STORE = 15'h001e;
    localparam logic [14:0] LOC_BLAST_XFER = 15'h001f;
    localparam logic [14:0] LOC_CHB_STORE = 15'h000c;
    localparam logic [14:0] LOC_CHC_STORE = 15'h000e;
    localparam logic [14:0] LOC_CHD_STORE = 15'h0010;
    localparam logic [14:0] LOC_CHE_STORE = 15'h0012;
    localparam logic [14:0] LOC_ONE = 15'h0001;
    // ------------------------------------------------------------
    // flag positions in a 36-bit word (word bit n at index 35-n)
    // ------------------------------------------------------------
    localparam int FLAG_PI = 18;
    localparam int FLAG_DD_LSB = 19;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 25_000_000;
    localparam int TIMER_RATE_HZ = 60;
    localparam int TICK_CYCLES_DEF = CLK_HZ / TIMER_RATE_HZ;
    localparam int TICK_W = 20;
    localparam logic [1:0] BLAST_COUNT = 2'h2;
endpackage : ctpl_pkg

// [core/ctpl_top.sv]
/*
 * Trap request, priority and enable logic for the protect, timer
 * overflow, direct-data and channel completion traps, with an APB slave.
 * Assumes the CPU pulses instr_done at each instruction completion and
 * accepts trap_take with its store, transfer and flag word.
 */
`timescale 1ns/1ps
`default_nettype none
module ctpl_top #(
    parameter int TICK_CYCLES = ctpl_pkg::TICK_CYCLES_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic instr_done,
    input wire logic between_instr,
    input wire logic priv_instr,
    input wire logic [3:0] dd_irq,
    input wire logic [3:0] chan_access,
    input wire logic [3:0] chan_busy,
    output logic trap_take,
    output logic [14:0] trap_store_addr,
    output logic [14:0] trap_xfer_addr,
    output logic [35:0] trap_flags,
    output logic cause_store_wr,
    output logic [14:0] cause_store_addr,
    output logic [14:0] cause_store_data,
    output logic blast_trap
);
    import ctpl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic trap_ctl, protect, chan_tc, timer_en;
    logic [3:0] dd_mask, op_mask, dd_pend, ch_pend, busy_q;
    logic ovf_pend, defer, pi_hold;
    logic [1:0] blocked;
    logic [31:0] timer;
    logic [TICK_W-1:0] tick_cnt;
    logic [14:0] last_store, last_xfer;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc = psel && penable && pready;
    wire wr = acc && pwrite;
    wire hit_ctrl = paddr == OFF_CTRL;
    wire hit_cmd = paddr == OFF_CMD;
    wire hit_mask = paddr == OFF_MASK;
    wire hit_pend = paddr == OFF_PEND;
    wire hit_timer = paddr == OFF_TIMER;
    wire hit_last = paddr == OFF_LAST;
    wire mapped = hit_ctrl | hit_cmd | hit_mask | hit_pend | hit_timer | hit_last;
    wire wr_ctrl = wr && hit_ctrl;
    wire wr_cmd = wr && hit_cmd;
    wire wr_timer = wr && hit_timer;
    wire cmd_spm = wr_cmd && pwdata[CMD_SPM];
    wire cmd_rct = wr_cmd && pwdata[CMD_RCT];
    wire cmd_enb = wr_cmd && pwdata[CMD_ENB];
    wire cmd_ict = wr_cmd && pwdata[CMD_ICT];
    wire cmd_rst = wr_cmd && pwdata[CMD_RST];
    wire [31:0] rd_ctrl = {28'h000_0000, timer_en, chan_tc, protect, trap_ctl};
    wire [31:0] rd_pend = {19'h0_0000, pi_hold, ch_pend, dd_pend, 1'b0, blocked, ovf_pend};
    wire [31:0] next_prdata = hit_ctrl ? rd_ctrl :
                              hit_mask ? {24'h00_0000, op_mask, dd_mask} :
                              hit_pend ? rd_pend :
                              hit_timer ? timer :
                              hit_last ? {1'b0, last_xfer, 1'b0, last_store} : 32'h0000_0000;

    // ------------------------------------------------------------
    // interval timer
    // ------------------------------------------------------------
    wire tick = timer_en && (tick_cnt == TICK_W'(TICK_CYCLES - 1));
    wire [32:0] timer_sum = {1'b0, timer} + 33'h0_0000_0001;
    wire step = tick && !ovf_pend;
    wire carry = step && timer_sum[32];
    wire blast = tick && ovf_pend && (blocked == BLAST_COUNT - 2'h1);

    // ------------------------------------------------------------
    // trap eligibility and priority
    // ------------------------------------------------------------
    wire eff_done = instr_done || pi_hold;
    wire eff_btw = between_instr || pi_hold;
    wire blk = (instr_done ? priv_instr : defer) && !pi_hold;
    wire [3:0] dd_live = dd_pend & dd_mask;
    wire ok_ovf = trap_ctl && ovf_pend && !blk && (eff_btw || eff_done);
    wire ok_dd = trap_ctl && chan_tc && (|dd_live) && !blk && eff_done;
    wire ok_ch = trap_ctl && chan_tc && (|ch_pend) && eff_done;
    wire any_cause = (ok_ovf || ok_dd || ok_ch) && !blast;
    wire take_pi = any_cause && protect;
    wire take_ovf = any_cause && !protect && ok_ovf;
    wire take_dd = any_cause && !protect && !ok_ovf && ok_dd;
    wire take_ch = any_cause && !protect && !ok_ovf && !ok_dd;
    wire [1:0] ch_idx = ch_pend[3] ? 2'h3 : ch_pend[2] ? 2'h2 : ch_pend[1] ? 2'h1 : 2'h0;
    wire [14:0] ch_store = ch_idx == 2'h3 ? LOC_CHE_STORE :
                           ch_idx == 2'h2 ? LOC_CHD_STORE :
                           ch_idx == 2'h1 ? LOC_CHC_STORE : LOC_CHB_STORE;
    wire [3:0] ch_onehot = 4'h1 << ch_idx;
    wire [14:0] cause_loc = ok_ovf ? LOC_OVF_STORE : ok_dd ? LOC_DD_STORE : ch_store;
    wire [35:0] dd_flags = {13'h0000, dd_live, 19'h0_0000};
    wire [35:0] pi_flags = 36'h0_0004_0000;
    wire [14:0] next_store = blast ? LOC_BLAST_STORE : take_pi ? LOC_PI_STORE :
                             take_ovf ? LOC_OVF_STORE : take_dd ? LOC_DD_STORE : ch_store;
    wire [14:0] next_xfer = blast ? LOC_BLAST_XFER : take_pi ? LOC_PI_XFER :
                            take_ovf ? LOC_OVF_XFER : take_dd ? LOC_DD_XFER :
                            ch_store + LOC_ONE;
    wire [35:0] next_flags = take_pi ? pi_flags : take_dd ? dd_flags : 36'h0_0000_0000;
    wire [3:0] ch_done = busy_q & ~chan_busy & op_mask;
    wire [3:0] dd_clr = (take_dd ? dd_mask : 4'h0) | (cmd_rst ? 4'hf : 4'h0) | chan_access;
    wire [3:0] ch_clr = (take_ch ? ch_onehot : 4'h0) | (cmd_rst ? 4'hf : 4'h0);

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // control triggers and masks
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_ctl <= RST_TRAP_CTL;
            timer_en <= RST_TIMER_EN;
            protect <= RST_PROTECT;
            chan_tc <= RST_CHAN_TC;
            dd_mask <= 4'h0;
            op_mask <= 4'h0;
        end else begin
            if (wr_ctrl) begin
                trap_ctl <= pwdata[CTRL_TRAP];
                timer_en <= pwdata[CTRL_TEN];
            end
            if (take_pi) begin
                protect <= 1'b0;
            end else if (cmd_spm) begin
                protect <= 1'b1;
            end
            if (take_dd || take_ch) begin
                chan_tc <= 1'b0;
            end else if (cmd_rct || cmd_enb) begin
                chan_tc <= 1'b1;
            end else if (cmd_ict) begin
                chan_tc <= 1'b0;
            end
            if (cmd_enb) begin
                dd_mask <= pwdata[CMD_DDM_LSB +: 4];
                op_mask <= pwdata[CMD_OPM_LSB +: 4];
            end
        end
    end

    // ------------------------------------------------------------
    // requests: timer, overflow, direct data, channels
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= '0;
            timer <= 32'h0000_0000;
            ovf_pend <= 1'b0;
            blocked <= 2'h0;
            dd_pend <= 4'h0;
            ch_pend <= 4'h0;
            busy_q <= 4'h0;
            defer <= 1'b0;
            pi_hold <= 1'b0;
        end else begin
            tick_cnt <= (!timer_en || tick) ? '0 : tick_cnt + 1'b1;
            if (wr_timer) begin
                timer <= pwdata;
            end else if (step) begin
                timer <= timer_sum[31:0];
            end
            if (carry) begin
                ovf_pend <= 1'b1;
            end else if (take_ovf || blast) begin
                ovf_pend <= 1'b0;
            end
            if (take_ovf || blast || !ovf_pend) begin
                blocked <= 2'h0;
            end else if (tick) begin
                blocked <= blocked + 2'h1;
            end
            dd_pend <= (dd_pend & ~dd_clr) | dd_irq;
            ch_pend <= (ch_pend & ~ch_clr) | ch_done;
            busy_q <= chan_busy;
            if (instr_done) begin
                defer <= priv_instr;
            end
            pi_hold <= take_pi;
        end
    end

    // ------------------------------------------------------------
    // trap outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trap_take <= 1'b0;
            blast_trap <= 1'b0;
            trap_store_addr <= 15'h0000;
            trap_xfer_addr <= 15'h0000;
            trap_flags <= 36'h0_0000_0000;
            cause_store_wr <= 1'b0;
            cause_store_addr <= 15'h0000;
            cause_store_data <= 15'h0000;
            last_store <= 15'h0000;
            last_xfer <= 15'h0000;
        end else begin
            trap_take <= any_cause || blast;
            blast_trap <= blast;
            trap_store_addr <= next_store;
            trap_xfer_addr <= next_xfer;
            trap_flags <= next_flags;
            cause_store_wr <= take_pi;
            cause_store_addr <= cause_loc;
            cause_store_data <= PI_CAUSE_DATA;
            if (any_cause || blast) begin
                last_store <= next_store;
                last_xfer <= next_xfer;
            end
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    property p_pi_loc;
        @(posedge pclk) disable iff (!presetn)
        take_pi |=> trap_take && trap_store_addr == LOC_PI_STORE && trap_flags[FLAG_PI];
    endproperty
    a_pi_loc: assert property (p_pi_loc) else $error("protect trap location wrong");

    property p_pi_off;
        @(posedge pclk) disable iff (!presetn)
        take_pi |=> !protect && pi_hold;
    endproperty
    a_pi_off: assert property (p_pi_off) else $error("protect mode not cleared");

    property p_pi_cause;
        @(posedge pclk) disable iff (!presetn)
        take_pi |=> cause_store_wr && cause_store_data == PI_CAUSE_DATA ##1 trap_take;
    endproperty
    a_pi_cause: assert property (p_pi_cause) else $error("cause trap did not follow");

    property p_ovf_set;
        @(posedge pclk) disable iff (!presetn)
        carry |=> ovf_pend;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("carry lost");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        ovf_pend && !wr_timer |=> $stable(timer) || $past(take_ovf);
    endproperty
    a_block: assert property (p_block) else $error("timer stepped while pending");

    property p_blast;
        @(posedge pclk) disable iff (!presetn)
        blast |=> blast_trap && trap_store_addr == LOC_BLAST_STORE && !ovf_pend;
    endproperty
    a_blast: assert property (p_blast) else $error("blast trap wrong");

    property p_needs_tc;
        @(posedge pclk) disable iff (!presetn)
        (take_ovf || take_dd || take_ch) |-> trap_ctl && !protect;
    endproperty
    a_needs_tc: assert property (p_needs_tc) else $error("trap taken while barred");

    property p_chtc_off;
        @(posedge pclk) disable iff (!presetn)
        (take_dd || take_ch) |=> !chan_tc && trap_take;
    endproperty
    a_chtc_off: assert property (p_chtc_off) else $error("channel trap control kept");

    property p_priv;
        @(posedge pclk) disable iff (!presetn)
        instr_done && priv_instr && !pi_hold |=> !(take_ovf || take_dd) until instr_done;
    endproperty
    a_priv: assert property (p_priv) else $error("trap not deferred");

    property p_order;
        @(posedge pclk) disable iff (!presetn)
        ok_ovf && any_cause && !protect |=> trap_store_addr == LOC_OVF_STORE;
    endproperty
    a_order: assert property (p_order) else $error("priority order wrong");

    property p_apb;
        @(posedge pclk) disable iff (!presetn)
        psel && penable && !pready |=> pready;
    endproperty
    a_apb: assert property (p_apb) else $error("apb answer late");

    c_pi: cover property (@(posedge pclk) disable iff (!presetn) take_pi ##2 trap_take);
    c_blast: cover property (@(posedge pclk) disable iff (!presetn) blast);
    c_dd: cover property (@(posedge pclk) disable iff (!presetn) take_dd && dd_live == 4'hf);
    c_ch: cover property (@(posedge pclk) disable iff (!presetn) take_ch && ch_idx == 2'h3);
endmodule // ctpl_top
`default_nettype wire

// [bench/ctpl_io_model.sv]
/*
 * Model of the I/O channels and direct-data devices that face the trap logic.
 * Assumes the bench calls its tasks from code aligned to the rising edge of pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module ctpl_io_model (
    input wire logic pclk,
    output logic [3:0] dd_irq,
    output logic [3:0] chan_access,
    output logic [3:0] chan_busy
);
    initial begin
        dd_irq = 4'h0;
        chan_access = 4'h0;
        chan_busy = 4'h0;
    end
    // one-cycle interrupt from the devices in m
    task automatic interrupt(input logic [3:0] m);
        @(posedge pclk);
        dd_irq <= m;
        @(posedge pclk);
        dd_irq <= 4'h0;
    endtask
    // program read or write on the channels in m
    task automatic access(input logic [3:0] m);
        @(posedge pclk);
        chan_access <= m;
        @(posedge pclk);
        chan_access <= 4'h0;
    endtask
    task automatic busy_set(input logic [3:0] m);
        @(posedge pclk);
        chan_busy <= chan_busy | m;
    endtask
    // channels go out of use: the only moment a completion may be flagged
    task automatic busy_clear(input logic [3:0] m);
        @(posedge pclk);
        chan_busy <= chan_busy & ~m;
    endtask
endmodule // ctpl_io_model
`default_nettype wire

// [bench/ctpl_top_tb_top.sv]
/*
 * Self-checking bench for the lower-priority trap logic: APB master, CPU
 * strobes and the I/O model. Assumes TICK_CYCLES of 8 and a 40 ns pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin comparisons++; if ((g) !== (x)) begin err_total++; \
    $display("[ERR] %0t got %h want %h", $time, (g), (x)); end end
module ctpl_top_tb_top;
    import ctpl_pkg::*;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} ctpl_row_t;
    localparam ctpl_row_t ROWS [13] = '{
        '{1'b0, OFF_CTRL, 32'h0000_0000, 32'h0000_0001, 1'b0},
        '{1'b0, OFF_MASK, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, OFF_TIMER, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b0, 8'h18, 32'h0000_0000, 32'h0000_0000, 1'b1},
        '{1'b1, OFF_CMD, 32'h0000_ff04, 32'h0000_0000, 1'b0},
        '{1'b0, OFF_MASK, 32'h0000_0000, 32'h0000_00ff, 1'b0},
        '{1'b0, OFF_CTRL, 32'h0000_0000, 32'h0000_0005, 1'b0},
        '{1'b1, OFF_CMD, 32'h0000_0008, 32'h0000_0000, 1'b0},
        '{1'b0, OFF_CTRL, 32'h0000_0000, 32'h0000_0001, 1'b0},
        '{1'b0, OFF_CMD, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{1'b1, 8'h1c, 32'h0000_0001, 32'h0000_0000, 1'b1},
        '{1'b1, OFF_TIMER, 32'hffff_fffe, 32'h0000_0000, 1'b0},
        '{1'b0, OFF_TIMER, 32'h0000_0000, 32'hffff_fffe, 1'b0}};
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic instr_done;
    logic between_instr;
    logic priv_instr;
    logic [3:0] dd_irq;
    logic [3:0] chan_access;
    logic [3:0] chan_busy;
    logic trap_take;
    logic [14:0] trap_store_addr;
    logic [14:0] trap_xfer_addr;
    logic [35:0] trap_flags;
    logic cause_store_wr;
    logic [14:0] cause_store_addr;
    logic [14:0] cause_store_data;
    logic blast_trap;
    logic [14:0] cap_store, cap_xfer, cap_ca, cap_cd;
    logic [35:0] cap_flags;
    logic cap_cw, cap_blast, got, e;
    logic [31:0] r, t;
    int err_total = 0;
    int comparisons = 0;
    ctpl_top #(.TICK_CYCLES(8)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr_done(instr_done),
        .between_instr(between_instr), .priv_instr(priv_instr), .dd_irq(dd_irq),
        .chan_access(chan_access), .chan_busy(chan_busy), .trap_take(trap_take),
        .trap_store_addr(trap_store_addr), .trap_xfer_addr(trap_xfer_addr),
        .trap_flags(trap_flags), .cause_store_wr(cause_store_wr),
        .cause_store_addr(cause_store_addr), .cause_store_data(cause_store_data),
        .blast_trap(blast_trap));
    ctpl_io_model i_io (.pclk(pclk), .dd_irq(dd_irq), .chan_access(chan_access),
        .chan_busy(chan_busy));
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    // ------------------------------------------------------------
    // bus and cpu helpers
    // ------------------------------------------------------------
    task automatic report_and_stop();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd_data, output logic rd_err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd_data = prdata;
        rd_err = pslverr;
        if (n >= 20) err_total++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        logic y;
        apb(1'b1, a, d, x, y);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] x);
        logic y;
        apb(1'b0, a, 32'h0000_0000, x, y);
    endtask
    task automatic done_pulse(input logic p);
        @(posedge pclk);
        instr_done <= 1'b1;
        priv_instr <= p;
        @(posedge pclk);
        instr_done <= 1'b0;
        priv_instr <= 1'b0;
    endtask
    task automatic wait_trap(input int lim);
        int n;
        got = 1'b0;
        n = 0;
        while (got !== 1'b1 && n < lim) begin
            @(posedge pclk);
            n++;
            if (trap_take === 1'b1) begin
                got = 1'b1;
                {cap_store, cap_xfer, cap_flags} = {trap_store_addr, trap_xfer_addr, trap_flags};
                {cap_cw, cap_ca, cap_cd} = {cause_store_wr, cause_store_addr, cause_store_data};
                cap_blast = blast_trap;
            end
        end
    endtask
    task automatic chk_trap(input int lim, input logic [14:0] s, input logic [14:0] x);
        wait_trap(lim);
        `CHK(got, 1'b1)
        `CHK(cap_store, s)
        `CHK(cap_xfer, x)
    endtask
    task automatic no_trap();
        done_pulse(1'b0);
        wait_trap(6);
        `CHK(got, 1'b0)
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        instr_done = 1'b0;
        between_instr = 1'b0;
        priv_instr = 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 13; i++) begin
            apb(ROWS[i].w, ROWS[i].a, ROWS[i].d, r, e);
            if (!ROWS[i].w) `CHK(r, ROWS[i].x)
            `CHK(e, ROWS[i].e)
        end
        wr(OFF_CMD, 32'h0000_0002);
        i_io.interrupt(4'h1);
        i_io.access(4'h1);
        no_trap();
        i_io.interrupt(4'h5);
        done_pulse(1'b1);
        wait_trap(4);
        `CHK(got, 1'b0)
        done_pulse(1'b0);
        chk_trap(10, LOC_DD_STORE, LOC_DD_XFER);
        `CHK(cap_flags, 36'h0_0028_0000)
        rd(OFF_CTRL, r);
        `CHK(r, 32'h0000_0001)
        rd(OFF_PEND, r);
        `CHK(r & 32'h0000_00f0, 32'h0000_0000)
        i_io.interrupt(4'h2);
        no_trap();
        wr(OFF_CMD, 32'h0000_0002);
        done_pulse(1'b0);
        chk_trap(10, LOC_DD_STORE, LOC_DD_XFER);
        `CHK(cap_flags, 36'h0_0010_0000)
        wr(OFF_CMD, 32'h0000_f104);
        wr(OFF_CMD, 32'h0000_0008);
        i_io.interrupt(4'h8);
        no_trap();
        wr(OFF_CMD, 32'h0000_f804);
        done_pulse(1'b0);
        chk_trap(10, LOC_DD_STORE, LOC_DD_XFER);
        `CHK(cap_flags, 36'h0_0040_0000)
        wr(OFF_CMD, 32'h0000_0002);
        wr(OFF_CMD, 32'h0000_0001);
        rd(OFF_CTRL, r);
        `CHK(r, 32'h0000_0007)
        i_io.interrupt(4'h8);
        done_pulse(1'b0);
        chk_trap(10, LOC_PI_STORE, LOC_PI_XFER);
        `CHK(cap_flags, 36'h0_0004_0000)
        `CHK({cap_cw, cap_ca, cap_cd}, {1'b1, LOC_DD_STORE, PI_CAUSE_DATA})
        chk_trap(2, LOC_DD_STORE, LOC_DD_XFER);
        rd(OFF_CTRL, r);
        `CHK(r, 32'h0000_0001)
        wr(OFF_CMD, 32'h0000_0002);
        i_io.busy_set(4'ha);
        i_io.busy_clear(4'ha);
        done_pulse(1'b0);
        chk_trap(10, LOC_CHE_STORE, LOC_CHE_STORE + LOC_ONE);
        wr(OFF_CMD, 32'h0000_0002);
        i_io.busy_set(4'h1);
        done_pulse(1'b0);
        chk_trap(10, LOC_CHC_STORE, LOC_CHC_STORE + LOC_ONE);
        wr(OFF_CMD, 32'h0000_0002);
        no_trap();
        i_io.busy_clear(4'h1);
        done_pulse(1'b0);
        chk_trap(10, LOC_CHB_STORE, LOC_CHB_STORE + LOC_ONE);
        wr(OFF_TIMER, 32'h0000_0000);
        wr(OFF_CTRL, 32'h0000_0009);
        repeat (80) @(posedge pclk);
        wr(OFF_CTRL, 32'h0000_0001);
        rd(OFF_TIMER, r);
        `CHK(r >= 32'h0000_0009 && r <= 32'h0000_000b, 1'b1)
        repeat (40) @(posedge pclk);
        rd(OFF_TIMER, t);
        `CHK(t, r)
        wr(OFF_TIMER, 32'hffff_ffff);
        @(posedge pclk);
        between_instr <= 1'b1;
        wr(OFF_CTRL, 32'h0000_0009);
        chk_trap(40, LOC_OVF_STORE, LOC_OVF_XFER);
        between_instr <= 1'b0;
        wr(OFF_CTRL, 32'h0000_0001);
        wr(OFF_TIMER, 32'hffff_ffff);
        wr(OFF_CTRL, 32'h0000_0009);
        chk_trap(60, LOC_BLAST_STORE, LOC_BLAST_XFER);
        `CHK(cap_blast, 1'b1)
        wr(OFF_CTRL, 32'h0000_0001);
        rd(OFF_TIMER, r);
        `CHK(r, 32'h0000_0000)
        wr(OFF_CTRL, 32'h0000_0000);
        wr(OFF_CMD, 32'h0000_0002);
        i_io.interrupt(4'h8);
        no_trap();
        wr(OFF_CTRL, 32'h0000_0001);
        done_pulse(1'b0);
        chk_trap(10, LOC_DD_STORE, LOC_DD_XFER);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(OFF_CTRL, r);
        `CHK(r, 32'h0000_0001)
        rd(OFF_MASK, r);
        `CHK(r, 32'h0000_0000)
        report_and_stop();
    end
    // watchdog: the sequence needs about 500 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        err_total++;
        report_and_stop();
    end
endmodule // ctpl_top_tb_top
`default_nettype wire
